// ===== verilog/rx_gain_pkg.sv
// Constants shared by the receive gain and filter control block.
// Assumes a single 200 MHz core clock and a plain register port.
package rx_gain_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [2:0] FILTER_CONFIG_OFFSET = 3'h0; // Filter zeros and low-pass corner
	localparam logic [2:0] FIRST_GAIN_OFFSET = 3'h1; // First stage gain and boost
	localparam logic [2:0] GAIN_CONFIG_OFFSET = 3'h2; // Initial state and loop enables
	localparam logic [2:0] MODE_OFFSET = 3'h3; // Operating mode for presets
	localparam logic [2:0] GAIN_STATUS_OFFSET = 3'h4; // Read-only gain state
	localparam logic [2:0] COMMAND_OFFSET = 3'h5; // Write-only command strobes

	// Field positions
	localparam int FG_BOOST_BIT = 3; // Boost enable in first gain register
	localparam int GC_AGC_EN_BIT = 4; // AGC enable
	localparam int GC_PRESET_BIT = 5; // AGC starts from preset position
	localparam int GC_SQ_AUTO_BIT = 6; // Automatic squelch while window is low
	localparam int CMD_RELOAD_BIT = 0; // Gain state reload
	localparam int CMD_DEFAULTS_BIT = 1; // Analog defaults
	localparam int CMD_MASK_BIT = 2; // Force window low
	localparam int CMD_UNMASK_BIT = 3; // Force window high
	localparam int CMD_SQUELCH_BIT = 4; // Start squelch run

	// Values after reset
	localparam logic [7:0] FILTER_CONFIG_RESET = 8'h00;
	localparam logic [3:0] FIRST_GAIN_RESET = 4'h6; // Six decrements, lowest gain
	localparam logic [7:0] GAIN_CONFIG_RESET = 8'h10; // AGC on, state 0
	localparam logic [2:0] MODE_RESET = 3'h0;

	// Gain state geometry
	localparam logic [3:0] STATE_MAX = 4'hA; // Eleven positions, 0 to 10
	localparam logic [3:0] WINDOW_MAX = 4'h4; // Five window levels
	localparam logic [3:0] AGC_PRESET_STATE = 4'h4; // Widest window, full gain
	localparam logic [2:0] FIRST_RED_MAX = 3'h6; // Six 2.5 dB decrements

	// Squelch interval
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SQUELCH_INTERVAL_US = 50;
	localparam int SQUELCH_CYCLES = SQUELCH_INTERVAL_US * 1000000 / CLK_PERIOD_PS;
	localparam logic [2:0] SQUELCH_LIMIT = 3'h2; // More than two transitions steps

	// Modes for the analog defaults command
	typedef enum logic [2:0] {
		MODE_A_128 = 3'b000,
		MODE_B_128 = 3'b001,
		MODE_FC32 = 3'b010,
		MODE_FC8 = 3'b011,
		MODE_FC64 = 3'b100,
		MODE_PEER = 3'b101,
		MODE_STREAM = 3'b110,
		MODE_TRANSPARENT = 3'b111
	} rx_mode_type;

endpackage

// ===== verilog/pin_sync.sv
// Two flip-flop synchroniser for levels from the analogue side.
// Assumes inputs are asynchronous to core_clk_in.
module pin_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q; // First stage, read only by second stage

	// ****************************************
	// Two-stage capture
	// ****************************************
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ===== verilog/squelch_counter.sv
// Squelch transition counter over fixed intervals.
// Assumes digitizer level is already synchronised.
module squelch_counter
	import rx_gain_pkg::*;
#(
	parameter int INTERVAL = 10000
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Control and data
	input wire logic run_in,
	input wire logic digitizer_in,
	output logic step_out
);

	logic [15:0] tick_q, tick_d; // Interval cycle counter
	logic [2:0] trans_q, trans_d; // Saturating transition count
	logic prev_q; // Last digitizer level
	logic step_d; // Interval ended noisy

	// Next-state logic; restart whenever not running
	always_comb begin
		tick_d = tick_q;
		trans_d = trans_q;
		step_d = 1'b0;
		if (!run_in) begin
			tick_d = '0;
			trans_d = '0;
		end else if (tick_q == 16'(INTERVAL - 1)) begin
			step_d = (trans_q > SQUELCH_LIMIT);
			tick_d = '0;
			trans_d = '0;
		end else begin
			tick_d = tick_q + 16'h0001;
			if ((digitizer_in != prev_q) && (trans_q != 3'h7)) begin
				trans_d = trans_q + 3'h1;
			end
		end
	end

	// Registers
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_q <= '0;
			trans_q <= '0;
			prev_q <= 1'b0;
			step_out <= 1'b0;
		end else begin
			tick_q <= tick_d;
			trans_q <= trans_d;
			prev_q <= digitizer_in;
			step_out <= step_d;
		end
	end

endmodule

// ===== verilog/rx_gain_filter_control.sv
// Receive chain filter, gain and gain-reduction state control.
// Assumes one 200 MHz clock, a plain register port, analogue comparators.
// Functional notes
// - First stage: max or six 2.5 dB cuts
// - Boost adds 5.5 dB to max
// - First stage gain changes by software only
// - Reset selects lowest first stage gain
// - Three bits choose first and third zeros
// - Bits 5..3 choose low-pass corner
// - Stages two/three: 23 dB, six 3 dB cuts
// - Reload resets loops, loads initial state
// - Five digitizer window levels, 3 dB apart
// - Gain state has eleven ordered positions
// - Four window steps, then six gain cuts
// - Default: narrow window, full gain
// - Loops start from programmed initial position
// - Status register shows gain state latched at window close or reload
// - Defaults command loads mode filter presets
// - Stream and transparent keep filter settings
// - Window rise starts AGC, fall latches status
// - Squelch steps when over two transitions
// - Window rises on mask expiry or commands
//
// Local design decisions: the placing of the registers and the strobed register port.
module rx_gain_filter_control
	import rx_gain_pkg::*;
#(
	parameter int SQUELCH_INTERVAL = SQUELCH_CYCLES
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	// Receive timing
	input wire logic mask_timer_expired_in,
	// Analogue comparators
	input wire logic digitizer_in,
	input wire logic agc_comparator_in,
	// Decoded analogue settings
	output logic [1:0] first_zero_out,
	output logic [1:0] third_zero_out,
	output logic lowpass_corner_bit2_out,
	output logic lowpass_corner_bit1_out,
	output logic lowpass_corner_bit0_out,
	output logic [2:0] first_gain_red_out,
	output logic boost_out,
	output logic [2:0] window_level_out,
	output logic [2:0] stage23_red_out,
	output logic rx_window_out,
	output logic loop_reset_out
);

	// ****************************************
	// Decode helpers
	// ****************************************

	// First zero: 0=60k, 1=40k, 2=12k; unused codes fall back to 60k
	function automatic logic [1:0] first_zero_fn(input logic [2:0] z);
		case (z)
			3'b010: first_zero_fn = 2'h1;
			3'b001, 3'b011, 3'b101: first_zero_fn = 2'h2;
			default: first_zero_fn = 2'h0;
		endcase
	endfunction

	// Third zero: 0=400k, 1=200k, 2=80k
	function automatic logic [1:0] third_zero_fn(input logic [2:0] z);
		case (z)
			3'b100, 3'b001, 3'b101: third_zero_fn = 2'h1;
			3'b010, 3'b011: third_zero_fn = 2'h2;
			default: third_zero_fn = 2'h0;
		endcase
	endfunction

	// Mode preset: low-pass in [5:3], zeros in [2:0]
	function automatic logic [5:0] preset_fn(input rx_mode_type m);
		case (m)
			MODE_B_128: preset_fn = 6'b000_100;
			MODE_FC32: preset_fn = 6'b100_010;
			MODE_FC8: preset_fn = 6'b101_100;
			MODE_FC64: preset_fn = 6'b000_011;
			MODE_PEER: preset_fn = 6'b000_101;
			default: preset_fn = 6'b000_000;
		endcase
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic [7:0] filter_config_q, filter_config_d; // Zeros and corner
	logic [3:0] first_gain_q, first_gain_d; // Reduction and boost
	logic [7:0] gain_config_q, gain_config_d; // Initial state and enables
	logic [2:0] mode_q, mode_d; // Preset mode
	logic [3:0] state_q, state_d; // Shared gain-reduction position
	logic [3:0] status_q, status_d; // Displayed gain state
	logic rx_on_q, rx_on_d; // Reception window
	logic squelch_q, squelch_d; // Squelch run active
	logic agc_prev_q; // Last AGC comparator level
	logic [7:0] rdata_d; // Read data next
	logic loop_reset_d; // Loop reset pulse next
	logic [1:0] sync_lv; // Synchronised comparator levels
	logic sq_step; // Squelch asks for a step
	logic agc_step; // AGC asks for a step
	logic write_cmd; // Command register write
	logic [3:0] init_state; // Programmed start, clamped

	assign write_cmd = reg_write_in && (reg_addr_in == COMMAND_OFFSET);
	// Clamp so an oversize initial value cannot leave the range
	assign init_state = (gain_config_q[3:0] > STATE_MAX) ? STATE_MAX : gain_config_q[3:0];

	// ****************************************
	// Comparator capture and squelch
	// ****************************************
	pin_sync #(
		.WIDTH(2)
	) comparator_sync (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.async_in({agc_comparator_in, digitizer_in}),
		.sync_out(sync_lv)
	);

	squelch_counter #(
		.INTERVAL(SQUELCH_INTERVAL)
	) squelch_unit (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.run_in(squelch_q),
		.digitizer_in(sync_lv[0]),
		.step_out(sq_step)
	);

	// AGC steps on each comparator transition while the window is open
	assign agc_step = rx_on_q && gain_config_q[GC_AGC_EN_BIT] && (sync_lv[1] != agc_prev_q);

	// ****************************************
	// Register writes, commands and gain state
	// ****************************************
	always_comb begin
		filter_config_d = filter_config_q;
		first_gain_d = first_gain_q;
		gain_config_d = gain_config_q;
		mode_d = mode_q;
		state_d = state_q;
		status_d = status_q;
		rx_on_d = rx_on_q;
		squelch_d = squelch_q;
		loop_reset_d = 1'b0;
		// Software writes; nothing else touches first gain
		if (reg_write_in) begin
			if (reg_addr_in == FILTER_CONFIG_OFFSET) begin
				filter_config_d = reg_wdata_in;
			end else if (reg_addr_in == FIRST_GAIN_OFFSET) begin
				// Steps beyond six are clamped
				first_gain_d[2:0] = (reg_wdata_in[2:0] > FIRST_RED_MAX) ?
					FIRST_RED_MAX : reg_wdata_in[2:0];
				first_gain_d[FG_BOOST_BIT] = reg_wdata_in[FG_BOOST_BIT];
			end else if (reg_addr_in == GAIN_CONFIG_OFFSET) begin
				gain_config_d = reg_wdata_in;
			end else if (reg_addr_in == MODE_OFFSET) begin
				mode_d = reg_wdata_in[2:0];
			end
		end
		// Window control; timer expiry wins over a mask in the same cycle
		if (write_cmd && reg_wdata_in[CMD_MASK_BIT]) begin
			rx_on_d = 1'b0;
		end else if (write_cmd && reg_wdata_in[CMD_UNMASK_BIT]) begin
			rx_on_d = 1'b1;
		end
		if (mask_timer_expired_in) begin
			rx_on_d = 1'b1;
		end
		// Squelch runs only while the window is low
		if (write_cmd && reg_wdata_in[CMD_SQUELCH_BIT] && !rx_on_q) begin
			squelch_d = 1'b1;
		end
		if (rx_on_q || (state_q == STATE_MAX)) begin
			squelch_d = gain_config_q[GC_SQ_AUTO_BIT] && !rx_on_q && (state_q != STATE_MAX);
		end else if (gain_config_q[GC_SQ_AUTO_BIT]) begin
			squelch_d = 1'b1;
		end
		// One step per cycle, saturating at the top
		if ((sq_step || agc_step) && (state_q != STATE_MAX)) begin
			state_d = state_q + 4'h1;
		end
		// Window opens: AGC starts from preset or programmed start
		if (rx_on_d && !rx_on_q && gain_config_q[GC_PRESET_BIT]) begin
			state_d = AGC_PRESET_STATE;
		end
		// Window closes: keep result, restart from programmed start
		if (!rx_on_d && rx_on_q) begin
			status_d = state_q;
			state_d = init_state;
		end
		// Reload command wins over loop activity
		if (write_cmd && reg_wdata_in[CMD_RELOAD_BIT]) begin
			state_d = init_state;
			status_d = init_state;
			squelch_d = 1'b0;
			loop_reset_d = 1'b1;
		end
		// Presets only where a mode has one
		if (write_cmd && reg_wdata_in[CMD_DEFAULTS_BIT] && (mode_q != MODE_STREAM) &&
			(mode_q != MODE_TRANSPARENT)) begin
			filter_config_d[5:0] = preset_fn(rx_mode_type'(mode_q));
		end
	end

	// Register the control group
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			filter_config_q <= FILTER_CONFIG_RESET;
			first_gain_q <= FIRST_GAIN_RESET;
			gain_config_q <= GAIN_CONFIG_RESET;
			mode_q <= MODE_RESET;
			state_q <= '0;
			status_q <= '0;
			rx_on_q <= 1'b0;
			squelch_q <= 1'b0;
			agc_prev_q <= 1'b0;
		end else begin
			filter_config_q <= filter_config_d;
			first_gain_q <= first_gain_d;
			gain_config_q <= gain_config_d;
			mode_q <= mode_d;
			state_q <= state_d;
			status_q <= status_d;
			rx_on_q <= rx_on_d;
			squelch_q <= squelch_d;
			agc_prev_q <= sync_lv[1];
		end
	end

	// ****************************************
	// Read port
	// ****************************************

	// Read mux; unmapped and command offsets read zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_read_in) begin
			if (reg_addr_in == FILTER_CONFIG_OFFSET) begin
				rdata_d = filter_config_q;
			end else if (reg_addr_in == FIRST_GAIN_OFFSET) begin
				rdata_d = {4'h0, first_gain_q};
			end else if (reg_addr_in == GAIN_CONFIG_OFFSET) begin
				rdata_d = gain_config_q;
			end else if (reg_addr_in == MODE_OFFSET) begin
				rdata_d = {5'h00, mode_q};
			end else if (reg_addr_in == GAIN_STATUS_OFFSET) begin
				rdata_d = {4'h0, status_q};
			end
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
			first_zero_out <= 2'h0;
			third_zero_out <= 2'h0;
			lowpass_corner_bit2_out <= 1'b0;
			lowpass_corner_bit1_out <= 1'b0;
			lowpass_corner_bit0_out <= 1'b0;
			first_gain_red_out <= FIRST_RED_MAX;
			boost_out <= 1'b0;
			window_level_out <= 3'h0;
			stage23_red_out <= 3'h0;
			rx_window_out <= 1'b0;
			loop_reset_out <= 1'b0;
		end else begin
			reg_rdata_out <= rdata_d;
			first_zero_out <= first_zero_fn(filter_config_q[2:0]);
			third_zero_out <= third_zero_fn(filter_config_q[2:0]);
			lowpass_corner_bit2_out <= filter_config_q[5];
			lowpass_corner_bit1_out <= filter_config_q[4];
			lowpass_corner_bit0_out <= filter_config_q[3];
			first_gain_red_out <= first_gain_q[2:0];
			boost_out <= first_gain_q[FG_BOOST_BIT];
			// Window widens first, then stage gain falls
			window_level_out <= (state_q > WINDOW_MAX) ? 3'h4 : state_q[2:0];
			stage23_red_out <= (state_q > WINDOW_MAX) ? 3'(state_q - WINDOW_MAX) : 3'h0;
			rx_window_out <= rx_on_q;
			loop_reset_out <= loop_reset_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	state_range_a: assert property (state_q <= STATE_MAX)
		else $error("gain state past top");
	window_full_a: assert property (state_q >= WINDOW_MAX |=> window_level_out == 3'h4)
		else $error("window not widest above step four");
	gain_full_a: assert property (state_q <= WINDOW_MAX |=> stage23_red_out == 3'h0)
		else $error("stage gain cut too early");
	reload_load_a: assert property (write_cmd && reg_wdata_in[CMD_RELOAD_BIT]
		|=> state_q == $past(init_state) && !squelch_q && loop_reset_out)
		else $error("reload did not load start state");
	status_latch_a: assert property ($fell(rx_on_q) && !loop_reset_out
		|-> status_q == $past(state_q))
		else $error("status not latched at window close");
	first_gain_sw_a: assert property (!(reg_write_in && reg_addr_in == FIRST_GAIN_OFFSET)
		|=> $stable(first_gain_q))
		else $error("first gain changed without write");
	preset_keep_a: assert property (write_cmd && reg_wdata_in[CMD_DEFAULTS_BIT] &&
		mode_q[2:1] == 2'b11 |=> $stable(filter_config_q))
		else $error("preset applied in raw mode");
	window_rise_a: assert property (mask_timer_expired_in
		|=> rx_on_q ##1 rx_window_out)
		else $error("window did not open on expiry");
	zero_decode_a: assert property (filter_config_q[2:0] == 3'b100
		|=> first_zero_out == 2'h0 && third_zero_out == 2'h1)
		else $error("zero decode wrong");

endmodule

// ===== bench/rx_gain_filter_control_bench.sv
// Self-checking bench for the receive gain and filter control block.
// Assumes the package constants and a squelch interval shortened to 20 cycles.
module rx_gain_filter_control_bench
	import rx_gain_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************
	// Stimulus signals
	// ****************************************
	logic core_clk_in = 1'b0; // 200 MHz core clock
	logic rst_n_in = 1'b0; // Reset held from time zero
	logic [2:0] reg_addr_in = 3'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_write_in = 1'b0;
	logic reg_read_in = 1'b0;
	logic mask_timer_expired_in = 1'b0;
	logic digitizer_in = 1'b0;
	logic agc_comparator_in = 1'b0;
	logic dig_toggle = 1'b0; // Noise generator on the digitizer
	logic [7:0] reg_rdata_out;
	logic [1:0] first_zero_out, third_zero_out;
	logic lowpass_corner_bit2_out, lowpass_corner_bit1_out, lowpass_corner_bit0_out;
	logic [2:0] first_gain_red_out, window_level_out, stage23_red_out;
	logic boost_out, rx_window_out, loop_reset_out;
	int errors = 0; // Mismatches seen
	int comparisons = 0; // Checks made
	int cycles = 0; // Hang guard

	// ****************************************
	// Device under test
	// ****************************************
	rx_gain_filter_control #(.SQUELCH_INTERVAL(20)) uut (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
		.reg_rdata_out(reg_rdata_out), .mask_timer_expired_in(mask_timer_expired_in),
		.digitizer_in(digitizer_in), .agc_comparator_in(agc_comparator_in),
		.first_zero_out(first_zero_out), .third_zero_out(third_zero_out),
		.lowpass_corner_bit2_out(lowpass_corner_bit2_out),
		.lowpass_corner_bit1_out(lowpass_corner_bit1_out),
		.lowpass_corner_bit0_out(lowpass_corner_bit0_out),
		.first_gain_red_out(first_gain_red_out), .boost_out(boost_out),
		.window_level_out(window_level_out), .stage23_red_out(stage23_red_out),
		.rx_window_out(rx_window_out), .loop_reset_out(loop_reset_out)
	);

	// Half period of 2.5 ns
	always #2.5 core_clk_in = ~core_clk_in;

	// Noise: a transition every cycle, far above the squelch limit
	always @(posedge core_clk_in) begin
		if (dig_toggle) begin
			digitizer_in <= ~digitizer_in;
		end
	end

	// Hang guard, well above the roughly 600 cycles the tests need
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("ERROR at %0t: timeout got %0h expected %0h", $time, cycles, 0);
			end_of_test();
		end
	end

	// ****************************************
	// Bus and check helpers
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask

	// One-cycle write, taken at the second edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge core_clk_in);
		reg_write_in <= 1'b0;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge core_clk_in);
		reg_read_in <= 1'b0;
		#1;
		check(reg_rdata_out, exp);
	endtask

	task automatic cmd(input int b);
		wr(COMMAND_OFFSET, 8'h01 << b);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset();
		check({5'h00, first_gain_red_out}, 8'h06);
		check({5'h00, window_level_out}, 8'h00);
		check({5'h00, stage23_red_out}, 8'h00);
		rdchk(FIRST_GAIN_OFFSET, 8'h06);
		rdchk(FILTER_CONFIG_OFFSET, 8'h00);
		rdchk(GAIN_CONFIG_OFFSET, 8'h10);
		wr(GAIN_STATUS_OFFSET, 8'hFF);
		rdchk(GAIN_STATUS_OFFSET, 8'h00);
		rdchk(3'h6, 8'h00);
		rdchk(COMMAND_OFFSET, 8'h00);
	endtask

	// Every valid zero code, lowpass codes cycled beside them
	task automatic test_filter();
		logic [2:0] z[6] = '{3'b000, 3'b100, 3'b010, 3'b001, 3'b011, 3'b101};
		logic [3:0] ft[6] = '{4'h0, 4'h1, 4'h6, 4'h9, 4'hA, 4'h9};
		logic [2:0] lp[6] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b101, 3'b001};
		for (int i = 0; i < 6; i++) begin
			wr(FILTER_CONFIG_OFFSET, {2'b00, lp[i], z[i]});
			tick(2);
			check({4'h0, first_zero_out, third_zero_out}, {4'h0, ft[i]});
			check({5'h00, lowpass_corner_bit2_out, lowpass_corner_bit1_out,
				lowpass_corner_bit0_out}, {5'h00, lp[i]});
			rdchk(FILTER_CONFIG_OFFSET, {2'b00, lp[i], z[i]});
		end
	endtask

	// All decrements, boost on for odd counts only, plus one past the end
	task automatic test_first_gain();
		for (int k = 0; k < 8; k++) begin
			wr(FIRST_GAIN_OFFSET, {4'h0, k[0], k[2:0]});
			tick(2);
			check({5'h00, first_gain_red_out}, (k > 6) ? 8'h06 : 8'(k));
			check({7'h00, boost_out}, {7'h00, k[0]});
		end
	endtask

	// Each initial position reloaded, with a clamp above ten
	task automatic test_reload();
		int e;
		for (int k = 0; k < 12; k++) begin
			e = (k > 10) ? 10 : k;
			wr(GAIN_CONFIG_OFFSET, 8'(k));
			cmd(CMD_RELOAD_BIT);
			// Pulse stands only until the next edge
			#1;
			check({7'h00, loop_reset_out}, 8'h01);
			tick(1);
			check({5'h00, window_level_out}, (e > 4) ? 8'h04 : 8'(e));
			check({5'h00, stage23_red_out}, (e > 4) ? 8'(e - 4) : 8'h00);
			check({7'h00, loop_reset_out}, 8'h00);
			rdchk(GAIN_STATUS_OFFSET, 8'(e));
		end
	endtask

	// Presets per mode; stream and transparent keep the old value
	task automatic test_defaults();
		logic [7:0] ex[8] = '{8'h00, 8'h04, 8'h22, 8'h2C, 8'h03, 8'h05, 8'h2D, 8'h2D};
		for (int m = 0; m < 8; m++) begin
			wr(MODE_OFFSET, 8'(m));
			wr(FILTER_CONFIG_OFFSET, 8'h2D);
			cmd(CMD_DEFAULTS_BIT);
			tick(2);
			rdchk(FILTER_CONFIG_OFFSET, ex[m]);
		end
	endtask

	// Squelch climbs from eight and stops at ten; reload drops it
	task automatic test_squelch();
		wr(FIRST_GAIN_OFFSET, 8'h03);
		wr(GAIN_CONFIG_OFFSET, 8'h08);
		cmd(CMD_RELOAD_BIT);
		cmd(CMD_SQUELCH_BIT);
		dig_toggle <= 1'b1;
		tick(150);
		check({5'h00, stage23_red_out}, 8'h06);
		check({5'h00, window_level_out}, 8'h04);
		check({5'h00, first_gain_red_out}, 8'h03);
		dig_toggle <= 1'b0;
		cmd(CMD_RELOAD_BIT);
		tick(2);
		check({5'h00, stage23_red_out}, 8'h04);
		// Automatic squelch while the window is low, AGC off
		wr(GAIN_CONFIG_OFFSET, 8'h48);
		cmd(CMD_RELOAD_BIT);
		dig_toggle <= 1'b1;
		tick(150);
		check({5'h00, stage23_red_out}, 8'h06);
		dig_toggle <= 1'b0;
	endtask

	// AGC steps while open; closing latches status and restores start
	task automatic test_agc();
		// Start two, AGC on, preset algorithm loads four on opening
		wr(GAIN_CONFIG_OFFSET, 8'h32);
		cmd(CMD_RELOAD_BIT);
		cmd(CMD_UNMASK_BIT);
		tick(2);
		check({7'h00, rx_window_out}, 8'h01);
		check({5'h00, window_level_out}, 8'h04);
		repeat (3) begin
			@(posedge core_clk_in);
			agc_comparator_in <= ~agc_comparator_in;
			tick(3);
		end
		tick(4);
		check({5'h00, window_level_out}, 8'h04);
		check({5'h00, stage23_red_out}, 8'h03);
		cmd(CMD_MASK_BIT);
		tick(3);
		check({7'h00, rx_window_out}, 8'h00);
		check({5'h00, window_level_out}, 8'h02);
		rdchk(GAIN_STATUS_OFFSET, 8'h07);
		@(posedge core_clk_in);
		mask_timer_expired_in <= 1'b1;
		@(posedge core_clk_in);
		mask_timer_expired_in <= 1'b0;
		tick(2);
		check({7'h00, rx_window_out}, 8'h01);
		check({5'h00, window_level_out}, 8'h04);
		cmd(CMD_MASK_BIT);
		tick(3);
	endtask

	// ****************************************
	// Main sequence and verdict
	// ****************************************
	task automatic end_of_test();
		$display("Comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		tick(1);
		test_reset();
		test_filter();
		test_first_gain();
		test_reload();
		test_defaults();
		test_agc();
		test_squelch();
		end_of_test();
	end

endmodule
